// ===== bidir_port.sv
`timescale 1ns/1ns
// ****************************************
// One bidirectional port: pins and read mux
// ****************************************
module bidir_port
	import gpio_bank_pkg::*;
#(
	parameter int               width    = 4,
	parameter logic [width-1:0] alt_rd   = '0,
	parameter logic [width-1:0] force_lo = '0
) (
	input  wire logic [width-1:0] data_q,
	input  wire logic [width-1:0] dir_q,
	input  wire logic [width-1:0] sel_q,
	input  wire logic [width-1:0] pin_level,
	input  wire logic [width-1:0] alt_out,
	output logic      [width-1:0] pin_out_d,
	output logic      [width-1:0] pin_oe_d,
	output logic      [width-1:0] pull_up_d,
	output logic      [width-1:0] read_val
);
	logic [width-1:0] alt_act;

	// Refuse a width the logic cannot serve
	if (width < 1 || width > 8) begin : g_bad_width
		$error("bidir_port width out of range");
	end

	// Pin drive, pull-up and read-back per bit
	always_comb begin
		alt_act   = dir_q & sel_q;
		pin_oe_d  = dir_q;
		pin_out_d = (alt_act & alt_out & ~force_lo)
			| (~alt_act & data_q);
		pull_up_d = ~dir_q & sel_q;
		read_val  = (~dir_q & pin_level)
			| (dir_q & ~(sel_q & alt_rd) & data_q)
			| (dir_q & sel_q & alt_rd & alt_out & ~force_lo);
	end
endmodule // bidir_port

// ===== gpio_bank_pkg.sv
package gpio_bank_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] analog_data_off     = 8'h00;
	localparam logic [7:0] interrupt_data_off  = 8'h04;
	localparam logic [7:0] serial_data_off     = 8'h08;
	localparam logic [7:0] serial_dir_off      = 8'h0c;
	localparam logic [7:0] serial_sel_off      = 8'h10;
	localparam logic [7:0] flash_data_off      = 8'h14;
	localparam logic [7:0] flash_dir_off       = 8'h18;
	localparam logic [7:0] flash_sel_off       = 8'h1c;
	localparam logic [7:0] strobe_data_off     = 8'h20;
	localparam logic [7:0] strobe_dir_off      = 8'h24;
	localparam logic [7:0] strobe_sel_off      = 8'h28;
	localparam logic [7:0] rmw_ctrl_off        = 8'h2c;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int analog_width    = 4;
	localparam int interrupt_width = 2;
	localparam int serial_width    = 4;
	localparam int flash_width     = 8;
	localparam int strobe_width    = 5;
	localparam int strobe_timer_bit = 4;
	localparam logic [7:0] port_clear_val = 8'h00;
	localparam logic [7:0] port_all_set   = 8'hff;

	// Read-modify-write operations
	typedef enum logic [1:0] {rmw_and, rmw_or, rmw_xor} rmw_op_t;

	// Read-modify-write control word fields
	localparam int rmw_op_lsb   = 8;
	localparam int rmw_port_lsb = 12;

endpackage

// ===== multi_port_gpio_bank.sv
`timescale 1ns/1ns
// ****************************************
// General-purpose port bank on AHB-Lite
// ****************************************
module multi_port_gpio_bank
	import gpio_bank_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        soft_reset,
	input  wire logic        external_access_pin_low,
	input  wire logic [3:0]  analog_pin,
	output logic      [3:0]  analog_input_zero,
	input  wire logic [1:0]  interrupt_pin,
	output logic      [1:0]  ext_interrupt_8_9,
	input  wire logic [3:0]  serial_pin_in,
	output logic      [3:0]  serial_pin_out,
	output logic      [3:0]  serial_pin_oe,
	output logic      [3:0]  serial_pull_up,
	input  wire logic        serial6_transmit_output,
	input  wire logic        serial6_receive_clock,
	input  wire logic        serial6_transmit_clock,
	output logic             serial6_receive_input,
	input  wire logic [7:0]  flash_pin_in,
	output logic      [7:0]  flash_pin_out,
	output logic      [7:0]  flash_pin_oe,
	output logic      [7:0]  flash_pull_up,
	input  wire logic [7:0]  flash_bus_out,
	input  wire logic [4:0]  strobe_pin_in,
	output logic      [4:0]  strobe_pin_out,
	output logic      [4:0]  strobe_pin_oe,
	output logic      [4:0]  strobe_pull_up,
	input  wire logic        flash_read_strobe_low,
	input  wire logic        flash_write_strobe_low,
	input  wire logic        timer4_output,
	input  wire logic        strobe_alt_out2
);
	// ****************************************
	// Synchronised pin levels
	// ****************************************
	logic [3:0] analog_s;
	logic [1:0] intr_s;
	logic [3:0] serial_s;
	logic [7:0] flash_s;
	logic [4:0] strobe_s;

	pin_sync #(.width(analog_width)) u_sync_analog (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.pin_async(analog_pin), .pin_sync_q(analog_s));
	pin_sync #(.width(interrupt_width)) u_sync_intr (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.pin_async(interrupt_pin), .pin_sync_q(intr_s));
	pin_sync #(.width(serial_width)) u_sync_serial (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.pin_async(serial_pin_in), .pin_sync_q(serial_s));
	pin_sync #(.width(flash_width)) u_sync_flash (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.pin_async(flash_pin_in), .pin_sync_q(flash_s));
	pin_sync #(.width(strobe_width)) u_sync_strobe (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.pin_async(strobe_pin_in), .pin_sync_q(strobe_s));

	// ****************************************
	// Port registers
	// ****************************************
	logic [3:0] serial_port_data_q;
	logic [3:0] serial_port_direction_q;
	logic [3:0] serial_port_alt_select_q;
	logic [7:0] flash_bus_port_data_q;
	logic [7:0] flash_bus_port_direction_q;
	logic [7:0] flash_bus_port_alt_select_q;
	logic [4:0] strobe_port_data_q;
	logic [4:0] strobe_port_direction_q;
	logic [4:0] strobe_port_alt_select_q;
	logic       ea_low_q;
	logic       strap_done_q;

	// Per-port mux outputs
	logic [3:0] serial_rd;
	logic [3:0] serial_out_d;
	logic [3:0] serial_oe_d;
	logic [3:0] serial_pu_d;
	logic [7:0] flash_rd;
	logic [7:0] flash_out_d;
	logic [7:0] flash_oe_d;
	logic [7:0] flash_pu_d;
	logic [4:0] strobe_rd;
	logic [4:0] strobe_out_d;
	logic [4:0] strobe_oe_d;
	logic [4:0] strobe_pu_d;

	// Serial port: bit 0 alternate output pinned low
	bidir_port #(.width(4), .alt_rd(4'hf), .force_lo(4'h1)) u_serial (
		.data_q(serial_port_data_q),
		.dir_q(serial_port_direction_q),
		.sel_q(serial_port_alt_select_q),
		.pin_level(serial_s),
		.alt_out({serial6_transmit_clock, serial6_receive_clock,
			serial6_transmit_output, 1'b0}),
		.pin_out_d(serial_out_d), .pin_oe_d(serial_oe_d),
		.pull_up_d(serial_pu_d), .read_val(serial_rd));

	// Flash port: read-back never shows the alternate value
	bidir_port #(.width(8), .alt_rd(8'h00), .force_lo(8'h00)) u_flash (
		.data_q(flash_bus_port_data_q),
		.dir_q(flash_bus_port_direction_q),
		.sel_q(flash_bus_port_alt_select_q),
		.pin_level(flash_s),
		.alt_out(flash_bus_out),
		.pin_out_d(flash_out_d), .pin_oe_d(flash_oe_d),
		.pull_up_d(flash_pu_d), .read_val(flash_rd));

	// Strobe port: only bit 4 reads its alternate value
	bidir_port #(.width(5), .alt_rd(5'h10), .force_lo(5'h00)) u_strobe (
		.data_q(strobe_port_data_q),
		.dir_q(strobe_port_direction_q),
		.sel_q(strobe_port_alt_select_q),
		.pin_level(strobe_s),
		.alt_out({timer4_output, 1'b0, strobe_alt_out2,
			flash_write_strobe_low, flash_read_strobe_low}),
		.pin_out_d(strobe_out_d), .pin_oe_d(strobe_oe_d),
		.pull_up_d(strobe_pu_d), .read_val(strobe_rd));

	// ****************************************
	// AHB-Lite slave: address phase capture
	// ****************************************
	logic       wr_pend_q;
	logic [7:0] addr_q;
	logic       acc_ok;

	assign acc_ok = hsel && hready && htrans[1];

	// Capture address phase; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= acc_ok && hwrite;
			if (acc_ok) begin
				addr_q <= haddr;
			end
		end
	end

	// Read value of each register; unmapped reads zero
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			analog_data_off:    v[3:0] = analog_s;
			interrupt_data_off: v[1:0] = intr_s;
			serial_data_off:    v[3:0] = serial_rd;
			serial_dir_off:     v[3:0] = serial_port_direction_q;
			serial_sel_off:     v[3:0] = serial_port_alt_select_q;
			flash_data_off:     v[7:0] = flash_rd;
			flash_dir_off:      v[7:0] = flash_bus_port_direction_q;
			flash_sel_off:      v[7:0] = flash_bus_port_alt_select_q;
			strobe_data_off:    v[4:0] = strobe_rd;
			strobe_dir_off:     v[4:0] = strobe_port_direction_q;
			strobe_sel_off:     v[4:0] = strobe_port_alt_select_q;
			default:            v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (acc_ok && !hwrite) begin
				hrdata <= reg_read(haddr);
			end
		end
	end

	// Always ready, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ****************************************
	// Read-modify-write: mux read, op, store
	// ****************************************
	logic [7:0] rmw_src;
	logic [7:0] rmw_res;
	rmw_op_t    rmw_op;

	// Operand bits [7:0], op [9:8], target data offset [19:12]
	always_comb begin
		rmw_op = rmw_op_t'(hwdata[rmw_op_lsb +: 2]);
		case (hwdata[rmw_port_lsb +: 8])
			serial_data_off: rmw_src = {4'h0, serial_rd};
			flash_data_off:  rmw_src = flash_rd;
			strobe_data_off: rmw_src = {3'h0, strobe_rd};
			default:         rmw_src = 8'h00;
		endcase
		case (rmw_op)
			rmw_and: rmw_res = rmw_src & hwdata[7:0];
			rmw_or:  rmw_res = rmw_src | hwdata[7:0];
			rmw_xor: rmw_res = rmw_src ^ hwdata[7:0];
			default: rmw_res = rmw_src;
		endcase
	end

	logic wr_rmw;
	assign wr_rmw = wr_pend_q && (addr_q == rmw_ctrl_off);

	// ****************************************
	// Register writes and reset behaviour
	// ****************************************
	// Strap the external-access level after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ea_low_q     <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (clk_en && !strap_done_q) begin
			ea_low_q     <= !external_access_pin_low;
			strap_done_q <= 1'b1;
		end
	end

	// Serial port registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_port_data_q       <= port_clear_val[3:0];
			serial_port_direction_q  <= port_clear_val[3:0];
			serial_port_alt_select_q <= port_clear_val[3:0];
		end else if (clk_en) begin
			if (soft_reset) begin
				serial_port_data_q       <= port_clear_val[3:0];
				serial_port_direction_q  <= port_clear_val[3:0];
				serial_port_alt_select_q <= port_clear_val[3:0];
			end else if (wr_rmw && hwdata[rmw_port_lsb +: 8]
				== serial_data_off) begin
				serial_port_data_q <= rmw_res[3:0];
			end else if (wr_pend_q) begin
				case (addr_q)
					serial_data_off: serial_port_data_q <= hwdata[3:0];
					serial_dir_off:  serial_port_direction_q <= hwdata[3:0];
					serial_sel_off:  serial_port_alt_select_q <= hwdata[3:0];
					default: ;
				endcase
			end
		end
	end

	// Flash port registers; strap decides reset mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_bus_port_data_q       <= port_clear_val;
			flash_bus_port_direction_q  <= port_clear_val;
			flash_bus_port_alt_select_q <= port_clear_val;
		end else if (clk_en) begin
			if (soft_reset || !strap_done_q) begin
				flash_bus_port_data_q <= port_clear_val;
				flash_bus_port_direction_q <= (soft_reset ? ea_low_q
					: !external_access_pin_low) ? port_all_set
					: port_clear_val;
				flash_bus_port_alt_select_q <= (soft_reset ? ea_low_q
					: !external_access_pin_low) ? port_all_set
					: port_clear_val;
			end else if (wr_rmw && hwdata[rmw_port_lsb +: 8]
				== flash_data_off) begin
				flash_bus_port_data_q <= rmw_res;
			end else if (wr_pend_q) begin
				case (addr_q)
					flash_data_off: flash_bus_port_data_q <= hwdata[7:0];
					flash_dir_off:  flash_bus_port_direction_q <= hwdata[7:0];
					flash_sel_off:  flash_bus_port_alt_select_q <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Strobe port registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe_port_data_q       <= port_clear_val[4:0];
			strobe_port_direction_q  <= port_clear_val[4:0];
			strobe_port_alt_select_q <= port_clear_val[4:0];
		end else if (clk_en) begin
			if (soft_reset) begin
				strobe_port_data_q       <= port_clear_val[4:0];
				strobe_port_direction_q  <= port_clear_val[4:0];
				strobe_port_alt_select_q <= port_clear_val[4:0];
			end else if (wr_rmw && hwdata[rmw_port_lsb +: 8]
				== strobe_data_off) begin
				strobe_port_data_q <= rmw_res[4:0];
			end else if (wr_pend_q) begin
				case (addr_q)
					strobe_data_off: strobe_port_data_q <= hwdata[4:0];
					strobe_dir_off:  strobe_port_direction_q <= hwdata[4:0];
					strobe_sel_off:  strobe_port_alt_select_q <= hwdata[4:0];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Registered pin and peripheral outputs
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_pin_out        <= 4'h0;
			serial_pin_oe         <= 4'h0;
			serial_pull_up        <= 4'h0;
			flash_pin_out         <= 8'h00;
			flash_pin_oe          <= 8'h00;
			flash_pull_up         <= 8'h00;
			strobe_pin_out        <= 5'h00;
			strobe_pin_oe         <= 5'h00;
			strobe_pull_up        <= 5'h00;
			analog_input_zero     <= 4'h0;
			ext_interrupt_8_9     <= 2'h0;
			serial6_receive_input <= 1'b0;
		end else if (clk_en) begin
			serial_pin_out        <= serial_out_d;
			serial_pin_oe         <= serial_oe_d;
			serial_pull_up        <= serial_pu_d;
			flash_pin_out         <= flash_out_d;
			flash_pin_oe          <= flash_oe_d;
			flash_pull_up         <= flash_pu_d;
			strobe_pin_out        <= strobe_out_d;
			strobe_pin_oe         <= strobe_oe_d;
			strobe_pull_up        <= strobe_pu_d;
			analog_input_zero     <= analog_s;
			ext_interrupt_8_9     <= intr_s;
			serial6_receive_input <= serial_s[0];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_wr_dir;
		wr_pend_q && addr_q == serial_dir_off && !soft_reset && clk_en;
	endsequence

	property p_serial_oe;
		@(posedge hclk) disable iff (!hresetn)
		clk_en |=> serial_pin_oe == $past(serial_port_direction_q);
	endproperty
	a_serial_oe: assert property (p_serial_oe)
		else $error("serial pin enable not following direction");

	property p_serial_bit0_low;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && serial_port_direction_q[0]
			&& serial_port_alt_select_q[0] |=> !serial_pin_out[0];
	endproperty
	a_serial_bit0_low: assert property (p_serial_bit0_low)
		else $error("serial bit 0 alternate output not low");

	property p_pullup;
		@(posedge hclk) disable iff (!hresetn)
		clk_en |=> strobe_pull_up == $past(~strobe_port_direction_q
			& strobe_port_alt_select_q);
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("strobe pull-up wrong");

	property p_dir_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_dir |=> serial_port_direction_q == $past(hwdata[3:0]);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("serial direction write lost");

	sequence s_soft_hit;
		clk_en && soft_reset;
	endsequence

	sequence s_ports_clear;
		strobe_port_direction_q == 5'h00 && serial_port_data_q == 4'h0
			&& serial_port_direction_q == 4'h0;
	endsequence

	// Registers clear first, the pin enable one enabled edge later
	property p_soft_clear;
		@(posedge hclk) disable iff (!hresetn)
		s_soft_hit |=> s_ports_clear
			##1 (!$past(clk_en) || serial_pin_oe == 4'h0);
	endproperty
	a_soft_clear: assert property (p_soft_clear)
		else $error("soft reset did not clear port");

	property p_flash_read;
		@(posedge hclk) disable iff (!hresetn)
		flash_rd == ((flash_bus_port_direction_q & flash_bus_port_data_q)
			| (~flash_bus_port_direction_q & flash_s));
	endproperty
	a_flash_read: assert property (p_flash_read)
		else $error("flash port read-back wrong");

	property p_timer_read;
		@(posedge hclk) disable iff (!hresetn)
		strobe_port_direction_q[4] && strobe_port_alt_select_q[4]
			|-> strobe_rd[4] == timer4_output;
	endproperty
	a_timer_read: assert property (p_timer_read)
		else $error("strobe bit 4 read not timer");

	property p_analog_route;
		@(posedge hclk) disable iff (!hresetn)
		clk_en |=> analog_input_zero == $past(analog_s);
	endproperty
	a_analog_route: assert property (p_analog_route)
		else $error("analog route mismatch");
endmodule // multi_port_gpio_bank

// ===== multi_port_gpio_bank_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
fail_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
// ****************
// Port bank bench
// ****************
module multi_port_gpio_bank_tb
	import gpio_bank_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
	logic        soft_reset = 1'b0, external_access_pin_low = 1'b1;
	logic        serial6_transmit_output = 1'b0, timer4_output = 1'b0;
	logic        serial6_receive_clock = 1'b0, strobe_alt_out2 = 1'b0;
	logic        serial6_transmit_clock = 1'b0, clk_en = 1'b1;
	logic        flash_read_strobe_low = 1'b0, flash_write_strobe_low = 1'b0;
	logic        hreadyout, hresp, serial6_receive_input;
	logic [1:0]  htrans = 2'b00, interrupt_pin = 2'b00, ext_interrupt_8_9;
	logic [2:0]  hsize = 3'b010;
	logic [3:0]  analog_pin = 4'h0, analog_input_zero;
	logic [3:0]  ser_en = 4'hf, ser_val = 4'h0, serial_pin_in;
	logic [3:0]  serial_pin_out, serial_pin_oe, serial_pull_up;
	logic [4:0]  stb_en = 5'h00, stb_val = 5'h00, strobe_pin_in;
	logic [4:0]  strobe_pin_out, strobe_pin_oe, strobe_pull_up;
	logic [7:0]  haddr = 8'h00, fl_en = 8'h00, fl_val = 8'h00;
	logic [7:0]  flash_bus_out = 8'h00, flash_pin_in, flash_pin_out;
	logic [7:0]  flash_pin_oe, flash_pull_up;
	logic [31:0] hwdata = 32'h0, hrdata, rd_s;
	int          fail_count = 0, check_count = 0;

	// Clock of 50 ns
	always #25 hclk = ~hclk;

	multi_port_gpio_bank uut (
		.hclk, .hresetn, .clk_en, .hsel(1'b1), .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .soft_reset, .external_access_pin_low,
		.analog_pin, .analog_input_zero, .interrupt_pin, .ext_interrupt_8_9,
		.serial_pin_in, .serial_pin_out, .serial_pin_oe, .serial_pull_up,
		.serial6_transmit_output, .serial6_receive_clock,
		.serial6_transmit_clock, .serial6_receive_input, .flash_pin_in,
		.flash_pin_out, .flash_pin_oe, .flash_pull_up, .flash_bus_out,
		.strobe_pin_in, .strobe_pin_out, .strobe_pin_oe, .strobe_pull_up,
		.flash_read_strobe_low, .flash_write_strobe_low, .timer4_output,
		.strobe_alt_out2
	);

	// Pin models
	pin_wire #(.w(4)) ser_w (.hclk, .out(serial_pin_out), .oe(serial_pin_oe),
		.pu(serial_pull_up), .ext_en(ser_en), .ext_val(ser_val),
		.lvl(serial_pin_in));
	pin_wire #(.w(8)) fl_w (.hclk, .out(flash_pin_out), .oe(flash_pin_oe),
		.pu(flash_pull_up), .ext_en(fl_en), .ext_val(fl_val),
		.lvl(flash_pin_in));
	pin_wire #(.w(5)) stb_w (.hclk, .out(strobe_pin_out),
		.oe(strobe_pin_oe), .pu(strobe_pull_up), .ext_en(stb_en),
		.ext_val(stb_val), .lvl(strobe_pin_in));

	// ****************
	// Bus tasks
	// ****************
	task automatic finish_test();
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Waits for hready at a rising edge, bounded; takes read data there
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd_s = hrdata;
		if (hreadyout !== 1'b1) begin
			fail_count++;
			finish_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rd_s)
	endtask

	task automatic settle();
		repeat (4) @(negedge hclk);
	endtask

	task automatic do_reset(input logic strap);
		@(posedge hclk);
		hresetn <= 1'b0;
		external_access_pin_low <= strap;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask

	task automatic rmw_chk(input rmw_op_t op, input logic [7:0] v,
		input logic [31:0] e);
		wr(rmw_ctrl_off, {12'h000, serial_data_off, 2'b00, op, v});
		rd(serial_data_off, e, "rmw");
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		rd(serial_dir_off, 32'h0, "ser dir");
		rd(serial_sel_off, 32'h0, "ser sel");
		rd(flash_dir_off, 32'h0, "fl dir");
		rd(strobe_dir_off, 32'h0, "stb dir");
		rd(strobe_sel_off, 32'h0, "stb sel");
		`CHK("ser oe", 4'h0, serial_pin_oe)
		`CHK("stb oe", 5'h00, strobe_pin_oe)
		wr(serial_dir_off, 32'hf);
		wr(strobe_dir_off, 32'h1f);
		wr(flash_dir_off, 32'hff);
		rd(serial_data_off, 32'h0, "ser data");
		rd(strobe_data_off, 32'h0, "stb data");
		rd(flash_data_off, 32'h0, "fl data");
	endtask

	task automatic t_inputs();
		@(posedge hclk);
		analog_pin <= 4'ha;
		interrupt_pin <= 2'b10;
		settle();
		rd(analog_data_off, 32'ha, "analog");
		rd(interrupt_data_off, 32'h2, "irq port");
		`CHK("adc", 4'ha, analog_input_zero)
		`CHK("irq", 2'b10, ext_interrupt_8_9)
		wr(8'h30, 32'hffffffff);
		rd(8'h30, 32'h0, "unmapped");
		`CHK("resp", 1'b0, hresp)
	endtask

	// Clock enable low freezes the A/D route
	task automatic t_freeze();
		@(posedge hclk);
		clk_en <= 1'b0;
		analog_pin <= 4'h5;
		settle();
		`CHK("frozen", 4'ha, analog_input_zero)
		@(posedge hclk);
		clk_en <= 1'b1;
		settle();
		`CHK("thawed", 4'h5, analog_input_zero)
	endtask

	task automatic t_serial();
		wr(serial_data_off, 32'hfffffff5);
		settle();
		`CHK("ser out", 4'h5, serial_pin_out)
		rd(serial_data_off, 32'h5, "ser data");
		@(posedge hclk);
		serial6_transmit_output <= 1'b1;
		serial6_receive_clock <= 1'b1;
		wr(serial_sel_off, 32'hf);
		settle();
		`CHK("ser alt", 4'h6, serial_pin_out)
		rd(serial_data_off, 32'h6, "ser alt");
		wr(serial_dir_off, 32'h0);
		@(posedge hclk);
		ser_en <= 4'h0;
		settle();
		`CHK("ser pu", 4'hf, serial_pull_up)
		`CHK("ser oe", 4'h0, serial_pin_oe)
		rd(serial_data_off, 32'hf, "ser pin");
		@(posedge hclk);
		ser_en <= 4'hf;
		ser_val <= 4'h8;
		settle();
		rd(serial_data_off, 32'h8, "ser pin");
		`CHK("ser rx", 1'b0, serial6_receive_input)
	endtask

	task automatic t_rmw();
		wr(rmw_ctrl_off, {12'h000, serial_data_off, 2'b00, rmw_or, 8'h00});
		wr(serial_sel_off, 32'h0);
		wr(serial_dir_off, 32'hf);
		rd(serial_data_off, 32'h8, "rmw pin");
		rmw_chk(rmw_or, 8'h03, 32'hb);
		rmw_chk(rmw_and, 8'h06, 32'h2);
		rmw_chk(rmw_xor, 8'hff, 32'hd);
	endtask

	task automatic t_flash();
		@(posedge hclk);
		fl_en <= 8'hf0;
		fl_val <= 8'h3c;
		flash_bus_out <= 8'h99;
		wr(flash_data_off, 32'ha5);
		wr(flash_dir_off, 32'h0f);
		wr(flash_sel_off, 32'h0f);
		settle();
		`CHK("fl oe", 8'h0f, flash_pin_oe)
		`CHK("fl alt", 8'h09, flash_pin_out & 8'h0f)
		rd(flash_data_off, 32'h35, "fl read");
		wr(flash_sel_off, 32'hf0);
		settle();
		`CHK("fl out", 8'h05, flash_pin_out & 8'h0f)
		`CHK("fl pu", 8'hf0, flash_pull_up)
		rd(flash_data_off, 32'h35, "fl read");
		wr(rmw_ctrl_off, {12'h000, flash_data_off, 2'b00, rmw_or, 8'h00});
		wr(flash_dir_off, 32'hff);
		rd(flash_data_off, 32'h35, "fl rmw");
	endtask

	task automatic t_strobe();
		@(posedge hclk);
		flash_read_strobe_low <= 1'b1;
		strobe_alt_out2 <= 1'b1;
		timer4_output <= 1'b1;
		wr(strobe_data_off, 32'h0a);
		settle();
		`CHK("stb out", 5'h0a, strobe_pin_out)
		wr(strobe_sel_off, 32'h1f);
		settle();
		`CHK("stb alt", 5'h15, strobe_pin_out)
		rd(strobe_data_off, 32'h1a, "stb alt");
		wr(strobe_sel_off, 32'h0);
		rd(strobe_data_off, 32'h0a, "stb data");
		wr(strobe_dir_off, 32'h0);
		@(posedge hclk);
		stb_en <= 5'h1f;
		stb_val <= 5'h11;
		settle();
		rd(strobe_data_off, 32'h11, "stb pin");
	endtask

	task automatic t_soft();
		wr(strobe_dir_off, 32'h1f);
		@(posedge hclk);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		rd(serial_dir_off, 32'h0, "soft ser");
		rd(strobe_dir_off, 32'h0, "soft stb");
		rd(flash_dir_off, 32'h0, "soft fl");
		do_reset(1'b0);
		rd(flash_dir_off, 32'hff, "strap dir");
		rd(flash_sel_off, 32'hff, "strap sel");
		rd(flash_data_off, 32'h0, "strap data");
		`CHK("strap oe", 8'hff, flash_pin_oe)
		wr(flash_dir_off, 32'h0);
		@(posedge hclk);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		rd(flash_dir_off, 32'hff, "soft strap");
	endtask

	// Main sequence
	initial begin
		do_reset(1'b1);
		t_reset();
		t_inputs();
		t_freeze();
		t_serial();
		t_rmw();
		t_flash();
		t_strobe();
		t_soft();
		finish_test();
	end
endmodule // multi_port_gpio_bank_tb

// ===== pin_sync.sv
`timescale 1ns/1ns
// ****************************************
// Two-flop synchroniser for pin levels
// ****************************************
module pin_sync
	import gpio_bank_pkg::*;
#(
	parameter int width = 1
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             clk_en,
	input  wire logic [width-1:0] pin_async,
	output logic      [width-1:0] pin_sync_q
);
	logic [width-1:0] meta_q;

	// Refuse a width the logic cannot serve
	if (width < 1) begin : g_bad_width
		$error("pin_sync width must be positive");
	end

	// First stage read only by the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q     <= '0;
			pin_sync_q <= '0;
		end else if (clk_en) begin
			meta_q     <= pin_async;
			pin_sync_q <= meta_q;
		end
	end
endmodule // pin_sync

// ===== pin_wire.sv
`timescale 1ns/1ns
// ****************
// Pin level model
// ****************
module pin_wire #(
	parameter int w = 4
) (
	input  wire logic         hclk,
	input  wire logic [w-1:0] out,
	input  wire logic [w-1:0] oe,
	input  wire logic [w-1:0] pu,
	input  wire logic [w-1:0] ext_en,
	input  wire logic [w-1:0] ext_val,
	output logic      [w-1:0] lvl
);
	logic [w-1:0] flt_q = '0;

	// Floating lines change every cycle
	always @(posedge hclk)
		flt_q <= ~flt_q;

	// Port drive, then outside driver, then pull-up
	always_comb begin
		for (int i = 0; i < w; i++) begin
			if (oe[i])
				lvl[i] = out[i];
			else if (ext_en[i])
				lvl[i] = ext_val[i];
			else if (pu[i])
				lvl[i] = 1'b1;
			else
				lvl[i] = flt_q[i];
		end
	end
endmodule // pin_wire
